//--- design/ttc_pkg.sv
// Package for the triple timer/event counter block.
// Assumes the block sits on an APB bus with 32-bit data, one register per word.
package ttc_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [7:0] TTC_IDX_C0_DATA = 8'h0D;
   localparam logic [7:0] TTC_IDX_C0_CTL = 8'h0E;
   localparam logic [7:0] TTC_IDX_C1_HIGH = 8'h0F;
   localparam logic [7:0] TTC_IDX_C1_LOW = 8'h10;
   localparam logic [7:0] TTC_IDX_C1_CTL = 8'h11;
   localparam logic [7:0] TTC_IDX_C2_HIGH = 8'h12;
   localparam logic [7:0] TTC_IDX_C2_LOW = 8'h13;
   localparam logic [7:0] TTC_IDX_C2_CTL = 8'h14;
   localparam logic [7:0] TTC_IDX_GEN_CTL = 8'h15;
   // Control register fields.
   localparam int TTC_PSC_LSB = 0;
   localparam int TTC_PSC_MSB = 2;
   localparam int TTC_EDGE_BIT = 3;
   localparam int TTC_RUN_BIT = 4;
   localparam int TTC_SRC_BIT = 5;
   localparam int TTC_MODE_LSB = 6;
   localparam int TTC_MODE_MSB = 7;
   localparam logic [7:0] TTC_CTL_RESET = 8'h08;
   // Mode codes.
   localparam logic [1:0] TTC_MODE_UNUSED = 2'h0;
   localparam logic [1:0] TTC_MODE_EVENT = 2'h1;
   localparam logic [1:0] TTC_MODE_TIMER = 2'h2;
   localparam logic [1:0] TTC_MODE_PULSE = 2'h3;
   // General control fields.
   localparam int TTC_GEN_SLOW_BIT = 0;
   localparam int TTC_GEN_TCK_LSB = 1;
   localparam int TTC_GEN_TCK_MSB = 2;
   localparam logic [7:0] TTC_GEN_RESET = 8'h00;
   localparam logic [1:0] TTC_TCK_SLOW = 2'h0;
   localparam logic [1:0] TTC_TCK_REF = 2'h1;
   localparam logic [1:0] TTC_TCK_SENSE = 2'h2;
   localparam logic [1:0] TTC_TCK_MODULE = 2'h3;
   // System clock divided by four.
   localparam logic [1:0] TTC_DIV4_LAST = 2'h3;
   // Synchronised inputs: three pins, two slow oscillators, three touch clocks.
   localparam int TTC_NSYNC = 8;
   localparam int TTC_S_RC = 3;
   localparam int TTC_S_XT = 4;
   localparam int TTC_S_REF = 5;
   localparam int TTC_S_SEN = 6;
   localparam int TTC_S_MOD = 7;
endpackage : ttc_pkg

//--- design/ttc_timers.sv
// Three count-up timer/event counters (one 8-bit, two 16-bit) behind an APB slave.
// Assumes pins and slow or touch clocks are asynchronous to pclk and much slower
// than it; every one of them is synchronised before use.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ttc_timers
   import ttc_pkg::*;
#(
   parameter int AW = 12,
   parameter int C0_W = 8,
   parameter int CNT_W = 16,
   parameter int PSC_W = 7
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output var logic [31:0] prdata,
   output var logic pready,
   output var logic pslverr,
   input wire logic [2:0] count_pin,
   input wire logic slow_rc_osc,
   input wire logic slow_crystal_osc,
   input wire logic touch_ref_clock,
   input wire logic touch_sense_clock,
   input wire logic touch_module_clock,
   output var logic [2:0] overflow_pulse
);

   // Byte registers and 16-bit counters are the only widths the decode can serve.
   // The address must reach above the index field, or the upper-zero test has no bits.
   initial begin
      if (C0_W != 8 || CNT_W != 16 || PSC_W != 7 || AW < 11) begin
         $error("ttc_timers: unsupported parameter values");
      end
   end

   // True when the prescaler has run through 2**sel base ticks.
   function automatic logic div_hit(input logic [PSC_W-1:0] cnt, input logic [2:0] sel);
      logic [PSC_W-1:0] mask;
      mask = PSC_W'((1 << sel) - 1);
      div_hit = ((cnt & mask) == mask);
   endfunction : div_hit

   // Largest count of a channel; counter 0 reloads at the top of its 8 bits.
   function automatic logic [CNT_W-1:0] top_of(input int ch);
      top_of = (ch == 0) ? CNT_W'((1 << C0_W) - 1) : {CNT_W{1'b1}};
   endfunction : top_of

   logic [7:0] ctl_r [3];
   logic [7:0] gen_r;
   logic [CNT_W-1:0] cnt_r [3];
   logic [CNT_W-1:0] pre_r [3];
   logic [7:0] lowbuf_r [3];
   logic [PSC_W-1:0] psc_r [3];
   logic [2:0] pw_act_r;
   logic [1:0] div4_r;
   logic [TTC_NSYNC-1:0] sync1_r;
   logic [TTC_NSYNC-1:0] sync2_r;
   logic [TTC_NSYNC-1:0] sync3_r;
   logic [TTC_NSYNC-1:0] rise;
   logic [TTC_NSYNC-1:0] fall;
   logic slow_tick;
   logic tck_tick;
   logic div4_tick;
   logic [2:0] int_base;
   logic [2:0] int_tick;
   logic [2:0] count_en;
   logic [2:0] pw_start;
   logic [2:0] pw_done;
   logic [2:0] at_top;
   logic [7:0] idx;
   logic in_range;
   logic setup;
   logic wr_done;
   logic [2:0] hit_hi;
   logic [2:0] hit_lo;
   logic [2:0] hit_ctl;
   logic hit_gen;
   logic hit_any;

   // Word index field of the byte address; bits outside it must be zero.
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 9;

   // Two flops before any logic; the third flop only serves edge detection.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
      end else begin
         sync1_r <= {touch_module_clock, touch_sense_clock, touch_ref_clock,
                     slow_crystal_osc, slow_rc_osc, count_pin};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // Edges come from the second and third flops, so a pin change acts three cycles late.
   assign rise = sync2_r & ~sync3_r;
   assign fall = ~sync2_r & sync3_r;

   // Free-running quarter-rate tick for counters 1 and 2.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div4_r <= '0;
      end else begin
         div4_r <= div4_r + 2'h1;
      end
   end

   // One cycle in four; counters 1 and 2 share it, so their timer ticks stay in step.
   assign div4_tick = (div4_r == TTC_DIV4_LAST);

   // Slow clock and counter 2 clock are selected as edge events, not as clocks.
   always_comb begin
      slow_tick = gen_r[TTC_GEN_SLOW_BIT] ? rise[TTC_S_XT] : rise[TTC_S_RC];
      case (gen_r[TTC_GEN_TCK_MSB:TTC_GEN_TCK_LSB])
         TTC_TCK_SLOW: tck_tick = slow_tick;
         TTC_TCK_REF: tck_tick = rise[TTC_S_REF];
         TTC_TCK_SENSE: tck_tick = rise[TTC_S_SEN];
         TTC_TCK_MODULE: tck_tick = rise[TTC_S_MOD];
         default: tck_tick = 1'b0;
      endcase
   end

   // Per-channel source selection, mode decode and count enable.
   always_comb begin
      for (int c = 0; c < 3; c++) begin
         logic [1:0] mode;
         logic run;
         logic edge_sel;
         mode = ctl_r[c][TTC_MODE_MSB:TTC_MODE_LSB];
         run = ctl_r[c][TTC_RUN_BIT];
         edge_sel = ctl_r[c][TTC_EDGE_BIT];
         if (c == 0) begin
            int_base[c] = ctl_r[c][TTC_SRC_BIT] ? slow_tick : 1'b1;
         end else if (c == 1) begin
            int_base[c] = ctl_r[c][TTC_SRC_BIT] ? slow_tick : div4_tick;
         end else begin
            int_base[c] = ctl_r[c][TTC_SRC_BIT] ? tck_tick : div4_tick;
         end
         int_tick[c] = int_base[c] & div_hit(psc_r[c], ctl_r[c][TTC_PSC_MSB:TTC_PSC_LSB]);
         // Edge bit 1 starts on rise and stops on fall; 0 is the reverse.
         pw_start[c] = edge_sel ? rise[c] : fall[c];
         pw_done[c] = 1'b0;
         // Event mode takes pin edges directly; the prescaler divides internal ticks only.
         case (mode)
            TTC_MODE_EVENT: begin
               count_en[c] = run & (edge_sel ? fall[c] : rise[c]);
            end
            TTC_MODE_TIMER: begin
               count_en[c] = run & int_tick[c];
            end
            TTC_MODE_PULSE: begin
               count_en[c] = run & pw_act_r[c] & int_tick[c];
               pw_done[c] = run & pw_act_r[c] & (edge_sel ? fall[c] : rise[c]);
            end
            default: begin
               count_en[c] = 1'b0;
            end
         endcase
         at_top[c] = (cnt_r[c] == top_of(c));
      end
   end

   // Address decode; data bits above the low byte are ignored on writes.
   assign idx = paddr[IDX_MSB:IDX_LSB];
   assign in_range = (paddr[AW-1:IDX_MSB+1] == '0) && (paddr[IDX_LSB-1:0] == '0);
   assign setup = psel & ~penable;
   assign wr_done = psel & penable & pready & pwrite;

   // One hit bit per channel; counter 0 data shares the high-byte slot.
   always_comb begin
      hit_hi = {in_range && idx == TTC_IDX_C2_HIGH, in_range && idx == TTC_IDX_C1_HIGH,
                in_range && idx == TTC_IDX_C0_DATA};
      hit_lo = {in_range && idx == TTC_IDX_C2_LOW, in_range && idx == TTC_IDX_C1_LOW, 1'b0};
      hit_ctl = {in_range && idx == TTC_IDX_C2_CTL, in_range && idx == TTC_IDX_C1_CTL,
                 in_range && idx == TTC_IDX_C0_CTL};
      hit_gen = in_range && idx == TTC_IDX_GEN_CTL;
      hit_any = (|hit_hi) | (|hit_lo) | (|hit_ctl) | hit_gen;
   end

   // Zero-wait APB slave: pready rises in the first access cycle and data is
   // sampled at the setup edge, so a read sees the count of that moment.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~hit_any;
         if (setup && !pwrite) begin
            // Unmapped reads find no hit and return zero with the error response.
            prdata <= '0;
            for (int c = 0; c < 3; c++) begin
               if (hit_hi[c]) begin
                  prdata[7:0] <= (c == 0) ? cnt_r[c][7:0] : cnt_r[c][15:8];
               end
               if (hit_lo[c]) begin
                  prdata[7:0] <= lowbuf_r[c];
               end
               if (hit_ctl[c]) begin
                  prdata[7:0] <= ctl_r[c];
               end
            end
            if (hit_gen) begin
               prdata[7:0] <= gen_r;
            end
         end
      end
   end

   // General control: slow clock source and counter 2 clock select.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gen_r <= TTC_GEN_RESET;
      end else if (wr_done && hit_gen) begin
         // Unused upper bits are kept and read back as written.
         gen_r <= pwdata[7:0];
      end
   end

   // Control registers; a software write wins over the automatic run clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < 3; c++) begin
            ctl_r[c] <= TTC_CTL_RESET;
         end
      end else begin
         for (int c = 0; c < 3; c++) begin
            if (wr_done && hit_ctl[c]) begin
               ctl_r[c] <= pwdata[7:0];
            end else if (pw_done[c]) begin
               ctl_r[c][TTC_RUN_BIT] <= 1'b0;
            end
         end
      end
   end

   // Low-byte buffer: filled by a low write or by a high read, so that a
   // following low read gives the low half of the same snapshot.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < 3; c++) begin
            lowbuf_r[c] <= '0;
         end
      end else begin
         for (int c = 1; c < 3; c++) begin
            if (wr_done && hit_lo[c]) begin
               lowbuf_r[c] <= pwdata[7:0];
            end else if (setup && !pwrite && hit_hi[c]) begin
               lowbuf_r[c] <= cnt_r[c][7:0];
            end
         end
      end
   end

   // Pulse measurement window; only one window per run bit setting.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pw_act_r <= '0;
      end else begin
         for (int c = 0; c < 3; c++) begin
            // A new start edge inside an open window changes nothing.
            if (ctl_r[c][TTC_MODE_MSB:TTC_MODE_LSB] != TTC_MODE_PULSE
                || !ctl_r[c][TTC_RUN_BIT] || pw_done[c]) begin
               pw_act_r[c] <= 1'b0;
            end else if (pw_start[c]) begin
               pw_act_r[c] <= 1'b1;
            end
         end
      end
   end

   // Prescalers advance on the internal base tick and clear while halted,
   // so each run starts with a full division period.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < 3; c++) begin
            psc_r[c] <= '0;
         end
      end else begin
         for (int c = 0; c < 3; c++) begin
            if (!ctl_r[c][TTC_RUN_BIT]) begin
               psc_r[c] <= '0;
            end else if (int_base[c]) begin
               psc_r[c] <= psc_r[c] + PSC_W'(1);
            end
         end
      end
   end

   // Preload registers change on every high or data write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < 3; c++) begin
            pre_r[c] <= '0;
         end
      end else begin
         for (int c = 0; c < 3; c++) begin
            // Counter 0 keeps its upper byte at zero, so the shared top compare holds.
            if (wr_done && hit_hi[c]) begin
               pre_r[c] <= (c == 0) ? {8'h00, pwdata[7:0]}
                                    : {pwdata[7:0], lowbuf_r[c]};
            end
         end
      end
   end

   // Counters: loaded by software only while halted, else count and reload.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < 3; c++) begin
            cnt_r[c] <= '0;
         end
      end else begin
         for (int c = 0; c < 3; c++) begin
            if (wr_done && hit_hi[c] && !ctl_r[c][TTC_RUN_BIT]) begin
               cnt_r[c] <= (c == 0) ? {8'h00, pwdata[7:0]}
                                    : {pwdata[7:0], lowbuf_r[c]};
            // Reads do not freeze the count; a read sees the value at its setup edge.
            end else if (count_en[c]) begin
               if (at_top[c]) begin
                  cnt_r[c] <= pre_r[c];
               end else begin
                  cnt_r[c] <= cnt_r[c] + CNT_W'(1);
               end
            end
         end
      end
   end

   // One-cycle overflow pulse per counter; the interrupt controller keeps the flag.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_pulse <= '0;
      end else begin
         // The pulse rises at the same edge that reloads the counter.
         overflow_pulse <= count_en & at_top;
      end
   end

endmodule : ttc_timers
`default_nettype wire

//--- bench/ttc_pin_model.sv
// Far-side model: the timer input pins and free-running slow and touch clocks.
// Assumes the bench supplies pclk; outputs are levels unrelated to the block.
`timescale 1ns/1ps
`default_nettype none
module ttc_pin_model #(
   parameter int HP_RC = 10,
   parameter int HP_XT = 13,
   parameter int HP_REF = 5,
   parameter int HP_SEN = 7,
   parameter int HP_MOD = 9
) (
   input wire logic pclk,
   input wire logic [2:0] pin_cmd,
   output var logic [2:0] count_pin,
   output var logic slow_rc_osc,
   output var logic slow_crystal_osc,
   output var logic touch_ref_clock,
   output var logic touch_sense_clock,
   output var logic touch_module_clock
);
   int cyc_r = 0;
   // Oscillators run free, so every clock keeps toggling between tests.
   always_ff @(posedge pclk) begin
      cyc_r <= cyc_r + 1;
   end
   // Each clock toggles after its own half period of pclk cycles.
   assign slow_rc_osc = 1'((cyc_r / HP_RC) % 2);
   assign slow_crystal_osc = 1'((cyc_r / HP_XT) % 2);
   assign touch_ref_clock = 1'((cyc_r / HP_REF) % 2);
   assign touch_sense_clock = 1'((cyc_r / HP_SEN) % 2);
   assign touch_module_clock = 1'((cyc_r / HP_MOD) % 2);
   // Pins hold whatever level the bench commands; they never float.
   assign count_pin = pin_cmd;
endmodule : ttc_pin_model
`default_nettype wire

//--- bench/ttc_timers_assertions.sv
// Checker for the timer block: APB answer timing and overflow gating.
// Assumes it is bound onto the block top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module ttc_timers_chk
   import ttc_pkg::*;
#(
   parameter int AW = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [2:0] overflow_pulse
);
   logic [2:0] on_r;
   logic [2:0] h1_r;
   logic [2:0] h2_r;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Shadow of run and a used mode per counter, from accepted writes only.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_r <= 3'h0;
      end else if (psel && penable && pready && pwrite && !pslverr) begin
         for (int c = 0; c < 3; c++) begin
            if (paddr[9:2] == TTC_IDX_C0_CTL + 8'(3 * c)) begin
               on_r[c] <= pwdata[4] && (pwdata[7:6] != 2'h0);
            end
         end
      end
   end
   // History spans the write-to-pulse latency, so no stale pulse is blamed.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         h1_r <= 3'h0;
         h2_r <= 3'h0;
      end else begin
         h1_r <= on_r;
         h2_r <= h1_r;
      end
   end
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_in_access_a: assert property (
      pready |-> psel && penable && $past(psel && !penable))
      else $error("ready outside access");
   ready_single_a: assert property (pready |=> !pready)
      else $error("ready held two cycles");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   map_err_a: assert property (psel && !penable && paddr[9:2] > 8'h15 |=> pslverr)
      else $error("unmapped access not refused");
   upper_zero_a: assert property (prdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data changed outside read");
   halt_no_ovf_a: assert property (!(|(overflow_pulse & ~(on_r | h1_r | h2_r))))
      else $error("overflow while counting off");
   cover property (overflow_pulse[0]);
   cover property (overflow_pulse[1]);
   cover property (overflow_pulse[2]);
   cover property (pslverr);
endmodule : ttc_timers_chk
`default_nettype wire

//--- bench/ttc_timers_tb.sv
// Self-checking bench for the three timers, driven over APB.
// Assumes the pin model supplies pins and clocks; the checker is bound below.
`timescale 1ns/1ps
`default_nettype none
module ttc_timers_tb import ttc_pkg::*; ;
   localparam int AW = 12;
   localparam int HP [5] = '{10, 13, 5, 7, 9};
   localparam logic [7:0] GEN [5] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h06};
   localparam logic [7:0] CI [3] = '{TTC_IDX_C0_CTL, TTC_IDX_C1_CTL, TTC_IDX_C2_CTL};
   localparam logic [7:0] HI [3] = '{8'h00, TTC_IDX_C1_HIGH, TTC_IDX_C2_HIGH};
   localparam logic [7:0] LO [3] = '{8'h00, TTC_IDX_C1_LOW, TTC_IDX_C2_LOW};
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr;
   logic [AW-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0] pin_cmd, count_pin, overflow_pulse;
   logic rc, xt, tref, tsen, tmod;
   int err_total = 0;
   int samples_checked = 0;
   ttc_timers dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .count_pin(count_pin), .slow_rc_osc(rc), .slow_crystal_osc(xt),
      .touch_ref_clock(tref), .touch_sense_clock(tsen), .touch_module_clock(tmod),
      .overflow_pulse(overflow_pulse));
   ttc_pin_model #(.HP_RC(HP[0]), .HP_XT(HP[1]), .HP_REF(HP[2]), .HP_SEN(HP[3]),
      .HP_MOD(HP[4])) u_pins (.pclk(pclk), .pin_cmd(pin_cmd), .count_pin(count_pin),
      .slow_rc_osc(rc), .slow_crystal_osc(xt), .touch_ref_clock(tref),
      .touch_sense_clock(tsen), .touch_module_clock(tmod));
   // Free-running 25 MHz clock.
   always #20 pclk = ~pclk;
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      samples_checked++;
      if (s !== x) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, x);
      end
   endtask : chk
   // One APB transfer; the request holds until pready is seen at an edge.
   task automatic apb(input logic w, input logic [AW-1:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic e);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         chk(32'h0, 32'h1);
         conclude();
      end
      q = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge, so the next call never drives psel twice in one step.
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      logic [7:0] q;
      logic e;
      apb(1'b1, {2'b00, i, 2'b00}, d, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] i, output logic [7:0] q);
      logic e;
      apb(1'b0, {2'b00, i, 2'b00}, 8'h00, q, e);
   endtask : rd
   // Preload F0 (FFF0) while halted, start, then time two overflow pulses.
   task automatic run_gap(input int c, input logic [7:0] ctl, input int x);
      int n, g;
      wr(CI[c], 8'h80);
      if (c == 0) begin
         wr(TTC_IDX_C0_DATA, 8'hF0);
      end else begin
         wr(LO[c], 8'hF0);
         wr(HI[c], 8'hFF);
      end
      wr(CI[c], ctl);
      for (n = 0; n < 2 * x + 20 && overflow_pulse[c] !== 1'b1; n++) @(posedge pclk);
      if (overflow_pulse[c] !== 1'b1) begin
         chk(32'h0, 32'h1);
         conclude();
      end
      @(posedge pclk);
      for (g = 1; g < 2 * x + 20 && overflow_pulse[c] !== 1'b1; g++) @(posedge pclk);
      chk(g, x);
      if (overflow_pulse[c] !== 1'b1) begin
         conclude();
      end
      wr(CI[c], 8'h80);
   endtask : run_gap
   task automatic t_reset();
      logic [7:0] q;
      for (int c = 0; c < 3; c++) begin
         rd(CI[c], q);
         chk(q, TTC_CTL_RESET);
      end
      rd(TTC_IDX_GEN_CTL, q);
      chk(q, TTC_GEN_RESET);
      $display("reset values done");
   endtask : t_reset
   // Low byte goes through the buffer; high read captures the live low.
   task automatic t_bytes();
      logic [7:0] q;
      for (int c = 1; c < 3; c++) begin
         wr(LO[c], 8'h34);
         rd(LO[c], q);
         chk(q, 8'h34);
         wr(HI[c], 8'h12);
         rd(HI[c], q);
         chk(q, 8'h12);
         wr(LO[c], 8'h77);
         rd(HI[c], q);
         chk(q, 8'h12);
         rd(LO[c], q);
         chk(q, 8'h34);
      end
      $display("byte buffer done");
   endtask : t_bytes
   task automatic t_clocks();
      for (int n = 0; n < 8; n++) run_gap(0, 8'h90 | 8'(n), 16 << n);
      for (int c = 1; c < 3; c++) run_gap(c, 8'h90, 64);
      for (int c = 0; c < 3; c++) run_gap(c, 8'hB0, 32 * HP[0]);
      for (int i = 1; i < 5; i++) begin
         wr(TTC_IDX_GEN_CTL, GEN[i]);
         run_gap(2, 8'hB0, 32 * HP[i]);
      end
      wr(TTC_IDX_GEN_CTL, 8'h00);
      $display("clock sources done");
   endtask : t_clocks
   // A rise alone counts only with edge bit 0; a running write is preload only.
   task automatic t_event();
      logic [7:0] q;
      for (int e = 0; e < 2; e++) begin
         wr(CI[0], 8'h40 | 8'(e << 3));
         wr(TTC_IDX_C0_DATA, 8'h10);
         wr(CI[0], 8'h50 | 8'(e << 3));
         wr(TTC_IDX_C0_DATA, 8'h33);
         pin_cmd[0] <= 1'b1;
         repeat (6) @(posedge pclk);
         rd(TTC_IDX_C0_DATA, q);
         chk(q, 8'h10 + 8'(1 - e));
         pin_cmd[0] <= 1'b0;
         repeat (6) @(posedge pclk);
         rd(TTC_IDX_C0_DATA, q);
         chk(q, 8'h11);
         wr(CI[0], 8'h40);
      end
      $display("event count done");
   endtask : t_event
   // Pins 1 and 2 clock their 16-bit counters; one rise carries into the high byte.
   task automatic t_event16();
      logic [7:0] q;
      for (int c = 1; c < 3; c++) begin
         wr(CI[c], 8'h40);
         wr(LO[c], 8'hFF);
         wr(HI[c], 8'h00);
         wr(CI[c], 8'h50);
         pin_cmd[c] <= 1'b1;
         repeat (6) @(posedge pclk);
         pin_cmd[c] <= 1'b0;
         repeat (6) @(posedge pclk);
         rd(HI[c], q);
         chk(q, 8'h01);
         rd(LO[c], q);
         chk(q, 8'h00);
         wr(CI[c], 8'h40);
      end
      $display("event count 16-bit done");
   endtask : t_event16
   task automatic t_pulse();
      logic [7:0] q, m;
      for (int e = 0; e < 2; e++) begin
         pin_cmd[0] <= 1'(1 - e);
         repeat (6) @(posedge pclk);
         wr(CI[0], 8'hC0 | 8'(e << 3));
         wr(TTC_IDX_C0_DATA, 8'h00);
         wr(CI[0], 8'hD0 | 8'(e << 3));
         for (int k = 0; k < 2; k++) begin
            pin_cmd[0] <= 1'(e);
            repeat (50 - 20 * k) @(posedge pclk);
            pin_cmd[0] <= 1'(1 - e);
            repeat (8) @(posedge pclk);
            rd(TTC_IDX_C0_DATA, q);
            if (k == 0) begin
               m = q;
               chk(q >= 8'h30 && q <= 8'h34, 1'b1);
               rd(CI[0], q);
               chk(q[4], 1'b0);
            end else begin
               chk(q, m);
            end
         end
      end
      $display("pulse width done");
   endtask : t_pulse
   task automatic t_unmapped();
      logic [7:0] q;
      logic e;
      apb(1'b0, 12'hFFC, 8'h00, q, e);
      chk({q, e}, 9'h001);
      $display("unmapped done");
   endtask : t_unmapped
   // Main sequence: every input set at time zero, reset for four cycles.
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0;
      pin_cmd = 3'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_bytes();
      t_clocks();
      t_event();
      t_event16();
      t_pulse();
      t_unmapped();
      conclude();
   end
endmodule : ttc_timers_tb
bind ttc_timers ttc_timers_chk #(.AW(AW)) u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .overflow_pulse(overflow_pulse));
`default_nettype wire
